//--- verif/line_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module line_tx_model (
    // Line
    output logic rxc,
    output logic rxd,
    output logic sync_n
);
    initial begin
        rxc = 1'b0;
        rxd = 1'b0;
        sync_n = 1'b1;
    end

    // ----------------------------------------
    // Bit transmission
    // ----------------------------------------
    // LSB first, data moves while the clock is low; clock stands still between frames
    task automatic send(input logic [15:0] v, input int n);
        #13;
        for (int i = 0; i < n; i++) begin
            rxd = v[i];
            #200 rxc = 1'b1;
            #200 rxc = 1'b0;
        end
        // Released line shows the opposite level, never a stale bit
        rxd = ~v[n-1];
    endtask : send

    task automatic ext_frame(input logic [15:0] pat, input int n, input logic [7:0] d);
        send(pat, n);
        // Outside logic needs two clocks to spot the pattern
        send(16'h0000, 2);
        sync_n = 1'b0;
        send({8'h00, d}, 8);
        sync_n = 1'b1;
    endtask : ext_frame
endmodule : line_tx_model
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sync_rx_pkg::*;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, resp;
    logic        sync_pin_o, sync_pin_oe, dtr_req_n, special_rx_int, ext_status_int;
    logic        carrier_detect_pin = 1'b0, tx_dma_req = 1'b0, sync_seen = 1'b0;
    wire logic   rxc_pin, rxd_pin, ext_sync_n, sync_wire;
    int          err_total = 0, samples_checked = 0;

    always #25 aclk = ~aclk;
    assign sync_wire = sync_pin_oe ? sync_pin_o : ext_sync_n;
    always @(posedge aclk) if (sync_pin_oe === 1'b1 && sync_pin_o === 1'b0) sync_seen <= 1'b1;

    line_tx_model tx (.rxc(rxc_pin), .rxd(rxd_pin), .sync_n(ext_sync_n));

    byte_sync_receiver dut (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .rxc_pin(rxc_pin), .rxd_pin(rxd_pin), .sync_pin_i(sync_wire),
        .sync_pin_o(sync_pin_o), .sync_pin_oe(sync_pin_oe),
        .carrier_detect_pin(carrier_detect_pin), .dtr_req_n(dtr_req_n),
        .tx_dma_req(tx_dma_req), .special_rx_int(special_rx_int),
        .ext_status_int(ext_status_int)
    );

    // ----------------------------------------
    // Common tasks
    // ----------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic bail(input string nm);
        err_total++;
        $display("FAIL %s expected answer seen timeout", nm);
        end_sim();
    endtask : bail

    // Address and data are offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1 && n < 40);
        bready <= 1'b0;
        resp = bresp;
        if (n >= 40) bail("write");
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 40);
        rready <= 1'b0;
        rd = rdata;
        resp = rresp;
        if (n >= 40) bail("read");
    endtask : rdr

    task automatic wait_avail();
        for (int i = 0; i < 30; i++) begin
            rdr(OFF_LSR);
            if (rd[LSR_AVAIL] === 1'b1) return;
        end
        bail("data available");
    endtask : wait_avail

    // Enable goes last; dropping it first forces a fresh hunt
    task automatic cfg(input logic [7:0] mode, ext, intc, rxctl);
        wr(OFF_MODE, mode);
        wr(OFF_EXT, ext);
        wr(OFF_SYN1, 8'h16);
        wr(OFF_SYN2, 8'h16);
        wr(OFF_RXC, rxctl & 8'hee);
        wr(OFF_TXC, 8'h00);
        wr(OFF_INTC, intc);
        wr(OFF_RXC, rxctl);
    endtask : cfg

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic sc_reset();
        rdr(OFF_MODE);
        chk("mode reset", rd, 32'h0);
        chk("sync drive", 32'(sync_pin_oe), 32'h1);
        chk("dtr idle", 32'(dtr_req_n), 32'h1);
        rdr(8'h3c);
        chk("unmapped resp", 32'(resp), 32'(RESP_SLVERR));
        wr(8'h3c, 8'h55);
        chk("unmapped write resp", 32'(resp), 32'(RESP_SLVERR));
    endtask : sc_reset

    task automatic sc_hunt();
        cfg(8'h00, 8'h00, 8'h01, 8'hd3);
        wr(OFF_CMD, 8'h10);
        rdr(OFF_LSR);
        chk("hunt set", 32'(rd[LSR_HUNT]), 32'h1);
        tx.send(16'h0016, 8);
        tx.send(16'ha516, 16);
        wait_avail();
        chk("sync pulse", 32'(sync_seen), 32'h1);
        chk("status int", 32'(ext_status_int), 32'h1);
        rdr(OFF_LSR);
        chk("hunt left", 32'(rd[LSR_HUNT]), 32'h0);
        rdr(OFF_DATA);
        chk("stripped data", rd, 32'ha5);
    endtask : sc_hunt

    task automatic sc_parity();
        for (int k = 0; k < 2; k++) begin
            cfg(k ? 8'h01 : 8'h03, 8'h00, 8'h04, 8'h11);
            wr(OFF_CMD, 8'h30);
            tx.send(16'h3516, 16);
            wait_avail();
            rdr(OFF_ESR);
            chk("parity flag", 32'(rd[ESR_PAR]), 32'(k));
            chk("parity int", 32'(special_rx_int), 32'(k));
            rdr(OFF_DATA);
            chk("short char", rd, 32'h35);
        end
        wr(OFF_CMD, 8'h30);
        rdr(OFF_ESR);
        chk("error reset", 32'(rd[ESR_PAR]), 32'h0);
    endtask : sc_parity

    task automatic sc_ext();
        cfg(8'h30, 8'h00, 8'h00, 8'hd1);
        chk("pin released", 32'(sync_pin_oe), 32'h0);
        rdr(OFF_LSR);
        chk("pin hunt", 32'(rd[LSR_HUNT]), 32'h1);
        tx.ext_frame(16'h0abc, 12, 8'h5a);
        wait_avail();
        rdr(OFF_DATA);
        chk("ext char", rd, 32'h5a);
    endtask : sc_ext

    task automatic sc_carrier();
        cfg(8'h00, 8'h00, 8'h00, 8'hf1);
        tx.send(16'h0f16, 12);
        @(posedge aclk);
        carrier_detect_pin <= 1'b1;
        repeat (6) @(posedge aclk);
        rdr(OFF_LSR);
        chk("carrier level", 32'(rd[LSR_CD]), 32'h1);
        carrier_detect_pin <= 1'b0;
        tx.send(16'h000f, 4);
        rdr(OFF_LSR);
        chk("partial dropped", 32'(rd[LSR_AVAIL]), 32'h0);
    endtask : sc_carrier

    // All-zero data keeps a zero checker zero; a preset of ones never clears
    task automatic sc_crc();
        for (int p = 0; p < 2; p++) begin
            cfg(8'h00, p ? 8'h00 : 8'h80, 8'h00, 8'hd9);
            tx.send(16'h0016, 16);
            wait_avail();
            rdr(OFF_DATA);
            tx.send(16'h0000, 8);
            wait_avail();
            rdr(OFF_ESR);
            chk("crc result", 32'(rd[ESR_CRC]), 32'(p == 0));
            rdr(OFF_DATA);
        end
        // A byte, then its check bits high-order first, leaves a zero residue two loads later
        for (int q = 0; q < 2; q++) begin
            wr(OFF_TXC, q ? 8'h04 : 8'h00);
            wr(OFF_RXC, 8'hd9);
            tx.send(16'h0116, 16);
            tx.send(q ? 16'hc0c1 : 16'h1189, 16);
            tx.send(16'h0000, 8);
            rdr(OFF_ESR);
            chk("crc midway", 32'(rd[ESR_CRC]), 32'h1);
            tx.send(16'h0000, 8);
            rdr(OFF_ESR);
            chk("crc residue", 32'(rd[ESR_CRC]), 32'h0);
        end
    endtask : sc_crc

    task automatic sc_dtr();
        wr(OFF_TXC, 8'h80);
        chk("dtr on", 32'(dtr_req_n), 32'h0);
        wr(OFF_INTC, 8'h40);
        for (int v = 0; v < 2; v++) begin
            @(posedge aclk);
            tx_dma_req <= v[0];
            @(posedge aclk);
            chk("dtr request", 32'(dtr_req_n), 32'(v == 0));
        end
    endtask : sc_dtr

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        sc_reset();
        sc_hunt();
        sc_parity();
        sc_ext();
        sc_carrier();
        sc_crc();
        sc_dtr();
        end_sim();
    end
endmodule : tb
`default_nettype wire

//--- verilog/byte_sync_receiver.sv
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module byte_sync_receiver
    import sync_rx_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Line
    input  wire logic        rxc_pin,
    input  wire logic        rxd_pin,
    input  wire logic        sync_pin_i,
    output logic             sync_pin_o,
    output logic             sync_pin_oe,
    input  wire logic        carrier_detect_pin,
    output logic             dtr_req_n,
    input  wire logic        tx_dma_req,
    // Condition outputs
    output logic             special_rx_int,
    output logic             ext_status_int
);

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
logic [2:0] rxc_q;
logic [1:0] rxd_q, syn_q, cd_q;
always_ff @(posedge aclk) begin
    if (!aresetn) begin
        rxc_q <= 3'h0;
        rxd_q <= 2'h0;
        syn_q <= 2'h3;
        cd_q  <= 2'h3;
    end else begin
        rxc_q <= {rxc_q[1:0], rxc_pin};
        rxd_q <= {rxd_q[0], rxd_pin};
        syn_q <= {syn_q[0], sync_pin_i};
        cd_q  <= {cd_q[0], carrier_detect_pin};
    end
end
wire bit_tick = rxc_q[1] & ~rxc_q[2];
wire rxd_s    = rxd_q[1];
wire sync_s   = syn_q[1];
wire cd_s     = cd_q[1];

// ----------------------------------------
// Bus slave
// ----------------------------------------
logic [7:0] intc_r, rxc_r, mode_r, txc_r, syn1_r, syn2_r, ext_r;
logic [7:0] awaddr_r, wdata_r;
logic       awv_r, wv_r, wstb_r, bvalid_r, rvalid_r;
logic [1:0] bresp_r, rresp_r;
logic [31:0] rdata_r;

assign awready = ~awv_r & ~bvalid_r;
assign wready  = ~wv_r & ~bvalid_r;
assign arready = ~rvalid_r;
assign bvalid  = bvalid_r;
assign bresp   = bresp_r;
assign rvalid  = rvalid_r;
assign rresp   = rresp_r;
assign rdata   = rdata_r;

wire wr_fire = awv_r & wv_r & ~bvalid_r;
wire rd_fire = arvalid & ~rvalid_r;
wire wr_map  = awaddr_r == OFF_CMD || awaddr_r == OFF_INTC || awaddr_r == OFF_RXC
            || awaddr_r == OFF_MODE || awaddr_r == OFF_TXC || awaddr_r == OFF_SYN1
            || awaddr_r == OFF_SYN2 || awaddr_r == OFF_EXT;
wire we       = wr_fire & wstb_r;
wire we_cmd   = we && awaddr_r == OFF_CMD;
wire hunt_cmd = we && awaddr_r == OFF_RXC && wdata_r[RXC_HUNT];
wire crc_cmd  = we_cmd && wdata_r[7:6] == CMD_CRC_RST;
wire err_cmd  = we_cmd && wdata_r[5:3] == CMD_ERR_RST;
wire estat_cmd = we_cmd && wdata_r[5:3] == CMD_EXT_RST;

always_ff @(posedge aclk) begin
    if (!aresetn) begin
        awv_r <= 1'b0;
        wv_r <= 1'b0;
        awaddr_r <= 8'h00;
        wdata_r <= 8'h00;
        wstb_r <= 1'b0;
        bvalid_r <= 1'b0;
        bresp_r <= RESP_OKAY;
    end else begin
        if (awvalid && awready) begin
            awv_r <= 1'b1;
            awaddr_r <= awaddr;
        end
        if (wvalid && wready) begin
            wv_r <= 1'b1;
            wdata_r <= wdata[7:0];
            wstb_r <= wstrb[0];
        end
        if (wr_fire) begin
            awv_r <= 1'b0;
            wv_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_map ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_r <= 1'b0;
        end
    end
end

// Enter-hunt bit is a command and never stored
always_ff @(posedge aclk) begin
    if (!aresetn) begin
        intc_r <= REG_RST;
        rxc_r  <= REG_RST;
        mode_r <= REG_RST;
        txc_r  <= REG_RST;
        syn1_r <= REG_RST;
        syn2_r <= REG_RST;
        ext_r  <= REG_RST;
    end else if (we) begin
        if (awaddr_r == OFF_INTC) intc_r <= wdata_r;
        if (awaddr_r == OFF_RXC)  rxc_r  <= wdata_r & 8'hef;
        if (awaddr_r == OFF_MODE) mode_r <= wdata_r;
        if (awaddr_r == OFF_TXC)  txc_r  <= wdata_r;
        if (awaddr_r == OFF_SYN1) syn1_r <= wdata_r;
        if (awaddr_r == OFF_SYN2) syn2_r <= wdata_r;
        if (awaddr_r == OFF_EXT)  ext_r  <= wdata_r;
    end
end

// ----------------------------------------
// Character framing
// ----------------------------------------
rx_state_t  state_r, state_nxt;
logic [15:0] shift_r;
logic [3:0] bit_cnt_r, pend_r;
logic       pend_par_r, sync_lo_r;

wire        ext_mode  = mode_r[5:4] == SYNC_EXT;
wire        rx_go     = rxc_r[RXC_EN] & ~(rxc_r[RXC_AUTO] & cd_s);
wire [3:0]  char_len  = {2'b00, rxc_r[7:6]} + 4'd5;
wire [3:0]  total     = char_len + {3'b000, mode_r[MODE_PAR]};
wire [15:0] shift_nxt = {rxd_s, shift_r[15:1]};
wire        m16 = shift_nxt == {syn2_r, syn1_r};
wire        m12 = shift_nxt[15:4] == {syn2_r, syn1_r[7:4]};
wire        m8  = shift_nxt[15:8] == syn2_r;
wire        m6  = shift_nxt[15:10] == syn2_r[5:0];
wire        sync_hit = mode_r[MODE_S12] ? (ext_r[EXT_SHORT] ? m12 : m16)
                                        : (ext_r[EXT_SHORT] ? m6 : m8);
wire        hunting  = state_r != ST_ASM;
wire        hunt_bit = ext_mode ? sync_s : hunting;
wire        lock_ext = ext_mode & ~sync_s;
wire        char_end = state_r == ST_ASM && bit_tick && bit_cnt_r + 4'd1 == total;
wire [8:0]  par_mask = 9'h1ff << (4'd9 - total);
wire        par_x    = ^(shift_nxt[15:7] & par_mask);
wire        par_bad  = mode_r[MODE_PAR] & (par_x ^ ~mode_r[MODE_EVEN]);
// Short characters wait so the upper bits are the bits that follow
wire        pend_go  = bit_tick && pend_r == 4'd1;
wire        long_go  = char_end && total >= 4'd8;
wire        load     = pend_go | long_go;
wire [7:0]  char8    = (long_go && total == 4'd9) ? shift_nxt[14:7] : shift_nxt[15:8];
wire        load_par = long_go ? par_bad : pend_par_r;
wire        strip    = rxc_r[RXC_INH] && char8 == syn1_r;
wire        wr_buf   = load & ~strip;

always_comb begin
    state_nxt = state_r;
    case (state_r)
        ST_OFF: state_nxt = ST_HUNT;
        ST_HUNT: begin
            if (bit_tick && (ext_mode ? lock_ext : sync_hit)) begin
                state_nxt = ST_ASM;
            end
        end
        ST_ASM: begin
            if (hunt_cmd) state_nxt = ST_HUNT;
        end
        default: state_nxt = ST_OFF;
    endcase
    if (!rx_go) state_nxt = ST_OFF;
end

always_ff @(posedge aclk) begin
    if (!aresetn) begin
        state_r <= ST_OFF;
        shift_r <= 16'h0000;
        bit_cnt_r <= 4'h0;
        pend_r <= 4'h0;
        pend_par_r <= 1'b0;
    end else begin
        state_r <= state_nxt;
        if (bit_tick) shift_r <= shift_nxt;
        if (state_nxt != ST_ASM) begin
            bit_cnt_r <= 4'h0;
            pend_r <= 4'h0;
        end else if (state_r != ST_ASM) begin
            bit_cnt_r <= ext_mode ? 4'h1 : 4'h0;
        end else if (bit_tick) begin
            bit_cnt_r <= char_end ? 4'h0 : bit_cnt_r + 4'd1;
            if (char_end && total < 4'd8) begin
                pend_r <= 4'd8 - total;
                pend_par_r <= par_bad;
            end else if (pend_r != 4'h0) begin
                pend_r <= pend_r - 4'd1;
            end
        end
    end
end

// While the receiver runs outside external sync mode, any match drives the pin, even mid-character
always_ff @(posedge aclk) begin
    if (!aresetn) begin
        sync_lo_r <= 1'b0;
    end else if (ext_mode || !rx_go) begin
        sync_lo_r <= 1'b0;
    end else if (bit_tick) begin
        sync_lo_r <= sync_hit;
    end
end
assign sync_pin_o  = ~sync_lo_r;
assign sync_pin_oe = ~ext_mode;

// ----------------------------------------
// Data buffer, errors and checker
// ----------------------------------------
logic [7:0]  data_r, dly_r;
logic        valid_r, first_r, hunt_q_r, estat_r;
logic [15:0] crc_r, crc_step;
rx_err_t     err_r;

wire        pop     = rd_fire && araddr == OFF_DATA;
wire [15:0] preset  = ext_r[EXT_PRE] ? CRC_ONES : CRC_ZEROS;
wire        crc_use = rxc_r[RXC_CRC] & first_r;

crc_byte u_crc (
    .crc_in  (crc_r),
    .data    (dly_r),
    .poly16  (txc_r[TXC_C16]),
    .crc_out (crc_step)
);

always_ff @(posedge aclk) begin
    if (!aresetn) begin
        crc_r <= CRC_ZEROS;
        dly_r <= 8'h00;
        first_r <= 1'b0;
    end else begin
        if (hunting || crc_cmd) begin
            crc_r <= preset;
        end else if (wr_buf && crc_use) begin
            crc_r <= crc_step;
        end
        if (hunting) first_r <= 1'b0;
        else if (wr_buf) first_r <= 1'b1;
        if (wr_buf) dly_r <= char8;
    end
end

always_ff @(posedge aclk) begin
    if (!aresetn) begin
        data_r <= 8'h00;
        valid_r <= 1'b0;
        err_r <= '0;
    end else begin
        if (wr_buf) begin
            data_r <= char8;
            err_r.crc <= |crc_r;
        end
        if (wr_buf) valid_r <= 1'b1;
        else if (pop) valid_r <= 1'b0;
        // A new error beats a simultaneous reset command
        if (wr_buf && load_par) err_r.par <= 1'b1;
        else if (err_cmd) err_r.par <= 1'b0;
        if (wr_buf && valid_r && !pop) err_r.ovr <= 1'b1;
        else if (err_cmd) err_r.ovr <= 1'b0;
    end
end

always_ff @(posedge aclk) begin
    if (!aresetn) begin
        hunt_q_r <= 1'b1;
        estat_r <= 1'b0;
    end else begin
        hunt_q_r <= hunt_bit;
        if (hunt_q_r != hunt_bit) estat_r <= 1'b1;
        else if (estat_cmd) estat_r <= 1'b0;
    end
end

assign special_rx_int = intc_r[INTC_PAR] & err_r.par;
assign ext_status_int = intc_r[INTC_EXT] & estat_r;
assign dtr_req_n = intc_r[INTC_DREQ] ? ~tx_dma_req : ~txc_r[TXC_DTR];

// ----------------------------------------
// Read path
// ----------------------------------------
logic [7:0] lsr, esr, rd_byte;
logic       rd_map;
always_comb begin
    lsr = 8'h00;
    lsr[LSR_AVAIL] = valid_r;
    lsr[LSR_CD] = cd_s;
    lsr[LSR_HUNT] = hunt_bit;
    esr = 8'h00;
    esr[ESR_PAR] = err_r.par;
    esr[ESR_OVR] = err_r.ovr;
    esr[ESR_CRC] = err_r.crc;
    rd_map = 1'b1;
    case (araddr)
        OFF_CMD:  rd_byte = 8'h00;
        OFF_INTC: rd_byte = intc_r;
        OFF_DATA: rd_byte = data_r;
        OFF_RXC:  rd_byte = rxc_r;
        OFF_MODE: rd_byte = mode_r;
        OFF_TXC:  rd_byte = txc_r;
        OFF_SYN1: rd_byte = syn1_r;
        OFF_SYN2: rd_byte = syn2_r;
        OFF_LSR:  rd_byte = lsr;
        OFF_ESR:  rd_byte = esr;
        OFF_EXT:  rd_byte = ext_r;
        default: begin
            rd_byte = 8'h00;
            rd_map = 1'b0;
        end
    endcase
end

always_ff @(posedge aclk) begin
    if (!aresetn) begin
        rvalid_r <= 1'b0;
        rdata_r <= 32'h0000_0000;
        rresp_r <= RESP_OKAY;
    end else if (rd_fire) begin
        rvalid_r <= 1'b1;
        rdata_r <= {24'h000000, rd_byte};
        rresp_r <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
        rvalid_r <= 1'b0;
    end
end

// ----------------------------------------
// Assertions
// ----------------------------------------
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);

sequence s_ext_lock;
    state_r == ST_HUNT && ext_mode && bit_tick && !sync_s && rx_go;
endsequence
sequence s_in_asm;
    state_r == ST_ASM;
endsequence

AST_EXT_PIN_IN: assert property (ext_mode |-> !sync_pin_oe)
    else $error("sync pin driven in external sync mode");
AST_EXT_STATUS: assert property (ext_mode |-> lsr[LSR_HUNT] == sync_s)
    else $error("hunt status does not follow sync pin");
AST_EXT_LOCK: assert property (s_ext_lock ##1 rx_go |-> s_in_asm)
    else $error("receiver stayed in hunt after sync pin low");
AST_SYNC_PULSE: assert property (!ext_mode && rx_go && bit_tick && sync_hit ##1 !ext_mode && rx_go
    |-> !sync_pin_o && sync_pin_oe)
    else $error("no sync pulse on match");
AST_STRIP: assert property (load && rxc_r[RXC_INH] && char8 == syn1_r |-> !wr_buf)
    else $error("sync character loaded despite inhibit");
AST_PAR_HOLD: assert property (err_r.par && !err_cmd |=> err_r.par)
    else $error("parity error flag lost before reset");
AST_HUNT_PRESET: assert property (hunting && !we |=> crc_r == preset)
    else $error("checker not preset during hunt");
AST_CRC_STILL: assert property (s_in_asm and (!wr_buf && !crc_cmd) |=> $stable(crc_r))
    else $error("checker moved between loads");
AST_FIRST_SKIP: assert property (s_in_asm and (!first_r && wr_buf && !crc_cmd) |=> crc_r == $past(crc_r))
    else $error("first character entered the checker");
AST_AUTO_STOP: assert property (rxc_r[RXC_AUTO] && cd_s |=> state_r == ST_OFF && bit_cnt_r == 4'h0)
    else $error("receiver ran with carrier lost");
AST_CRC_LATCH: assert property (wr_buf |=> err_r.crc == |$past(crc_r))
    else $error("crc result not latched with data");

endmodule : byte_sync_receiver
`default_nettype wire

//--- verilog/crc_byte.sv
`timescale 1ns/1ps
`default_nettype none
module crc_byte
    import sync_rx_pkg::*;
(
    // Step
    input  wire logic [15:0] crc_in,
    input  wire logic [7:0]  data,
    input  wire logic        poly16,
    output logic      [15:0] crc_out
);
    // Data enters least significant bit first, as it came off the line
    always_comb begin
        logic [15:0] c;
        logic [15:0] p;
        c = crc_in;
        p = poly16 ? POLY_CRC16 : POLY_CCITT;
        for (int i = 0; i < 8; i++) begin
            if (c[15] ^ data[i]) begin
                c = {c[14:0], 1'b0} ^ p;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        crc_out = c;
    end
endmodule : crc_byte
`default_nettype wire

//--- verilog/sync_rx_pkg.sv
package sync_rx_pkg;

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
localparam logic [7:0] OFF_CMD  = 8'h00;
localparam logic [7:0] OFF_INTC = 8'h04;
localparam logic [7:0] OFF_DATA = 8'h08;
localparam logic [7:0] OFF_RXC  = 8'h0c;
localparam logic [7:0] OFF_MODE = 8'h10;
localparam logic [7:0] OFF_TXC  = 8'h14;
localparam logic [7:0] OFF_SYN1 = 8'h18;
localparam logic [7:0] OFF_SYN2 = 8'h1c;
localparam logic [7:0] OFF_LSR  = 8'h20;
localparam logic [7:0] OFF_ESR  = 8'h24;
localparam logic [7:0] OFF_EXT  = 8'h28;
localparam logic [7:0] REG_RST  = 8'h00;

// ----------------------------------------
// Field positions
// ----------------------------------------
localparam int RXC_EN    = 0;
localparam int RXC_INH   = 1;
localparam int RXC_CRC   = 3;
localparam int RXC_HUNT  = 4;
localparam int RXC_AUTO  = 5;
localparam int MODE_PAR  = 0;
localparam int MODE_EVEN = 1;
localparam int MODE_S12  = 4;
localparam int TXC_C16   = 2;
localparam int TXC_DTR   = 7;
localparam int EXT_SHORT = 0;
localparam int EXT_PRE   = 7;
localparam int INTC_EXT  = 0;
localparam int INTC_PAR  = 2;
localparam int INTC_DREQ = 6;
localparam int LSR_AVAIL = 0;
localparam int LSR_CD    = 3;
localparam int LSR_HUNT  = 4;
localparam int ESR_PAR   = 4;
localparam int ESR_OVR   = 5;
localparam int ESR_CRC   = 6;

// ----------------------------------------
// Codes and constants
// ----------------------------------------
localparam logic [1:0]  SYNC_EXT     = 2'h3;
localparam logic [1:0]  CMD_CRC_RST  = 2'h1;
localparam logic [2:0]  CMD_EXT_RST  = 3'h2;
localparam logic [2:0]  CMD_ERR_RST  = 3'h6;
localparam logic [15:0] POLY_CRC16   = 16'h8005;
localparam logic [15:0] POLY_CCITT   = 16'h1021;
localparam logic [15:0] CRC_ONES     = 16'hffff;
localparam logic [15:0] CRC_ZEROS    = 16'h0000;
localparam logic [1:0]  RESP_OKAY    = 2'h0;
localparam logic [1:0]  RESP_SLVERR  = 2'h2;

typedef struct packed {
    logic crc;
    logic ovr;
    logic par;
} rx_err_t;

typedef enum logic [2:0] {
    ST_OFF  = 3'b001,
    ST_HUNT = 3'b010,
    ST_ASM  = 3'b100
} rx_state_t;

endpackage : sync_rx_pkg
